// ### include/eid_pkg.sv
package eid_pkg;
	// Register bus geometry.
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int PIN_N = 6;
	localparam int ENC_N = 4;
	localparam int STAT_W = 7;

	// Register offsets.
	localparam logic [3:0] OFF_SENSE = 4'h0;
	localparam logic [3:0] OFF_FLAGS = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h8;
	localparam logic [3:0] OFF_MASK = 4'hC;

	// Sense control fields and reset value.
	localparam logic [15:0] SENSE_RST = 16'h4000;
	localparam int BIT_MASK_ALL = 15;
	localparam int BIT_ENC_SEL = 14;
	localparam int BIT_BL_OVR = 13;
	localparam logic [15:0] SENSE_WMASK = 16'hEFFF;

	// Request flag and status register reset values, and status register layout.
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [STAT_W-1:0] STAT_RST = 7'h00;
	localparam int STAT_NMI_BIT = 6;

	// Two-bit sense codes.
	typedef enum logic [1:0] {
		SENSE_FALL = 2'h0,
		SENSE_RISE = 2'h1,
		SENSE_LOW = 2'h2,
		SENSE_HIGH = 2'h3
	} eid_sense_t;
endpackage : eid_pkg

// ### verification/eid_pin_model.sv
`timescale 1ns/1ps
// Stands in for the external devices that drive the request and non-maskable pins.
module eid_pin_model (
	input wire logic clk,
	input wire logic [6:0] want,
	output logic [5:0] pins,
	output logic nmi
);
	// Lines idle high and move just after a rising edge, as a clocked driver would.
	initial {nmi, pins} = 7'h7F;
	always @(posedge clk) begin
		{nmi, pins} <= want;
	end
endmodule : eid_pin_model

// ### verification/eid_top_sva.sv
`timescale 1ns/1ps
// Watches the register port and the processor request outputs of the detector.
module eid_chk (
	CORE_CLK,
	RST_B,
	STANDBY,
	REG_ADDR,
	REG_RD,
	REG_RDATA,
	CPU_PIN_REQ,
	CPU_ENC_LEVEL,
	CPU_NMI_REQ
);
	import eid_pkg::*;
	input wire logic CORE_CLK;
	input wire logic RST_B;
	input wire logic STANDBY;
	input wire logic [eid_pkg::ADDR_W-1:0] REG_ADDR;
	input wire logic REG_RD;
	input wire logic [eid_pkg::DATA_W-1:0] REG_RDATA;
	input wire logic [eid_pkg::PIN_N-1:0] CPU_PIN_REQ;
	input wire logic [eid_pkg::ENC_N-1:0] CPU_ENC_LEVEL;
	input wire logic CPU_NMI_REQ;

	// All checks run on the core clock and rest while reset is low.
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_B);

	// Read data only appears in the cycle after a read strobe.
	a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == '0)
		else $error("Read data seen without a read");
	a_sense_resv: assert property ($past(REG_RD) && $past(REG_ADDR) == OFF_SENSE |-> !REG_RDATA[12])
		else $error("Reserved sense bit read as one");
	a_flags_resv: assert property ($past(REG_RD) && $past(REG_ADDR) == OFF_FLAGS |-> REG_RDATA[15:6] == '0)
		else $error("Reserved flag bits read as one");
	a_unmapped_zero: assert property ($past(REG_RD) && $past(REG_ADDR[1:0]) != 2'h0 |-> REG_RDATA == '0)
		else $error("Unmapped address returned data");
	a_high_zero: assert property ($past(REG_RD) && $past(REG_ADDR[3]) |-> REG_RDATA[15:7] == '0)
		else $error("Status or mask upper bits read as one");
	// The non-maskable request is a single pulse and never leaves in standby.
	a_standby_nmi: assert property (CPU_NMI_REQ |-> !$past(STANDBY))
		else $error("Non-maskable request raised in standby");
	a_nmi_pulse: assert property (CPU_NMI_REQ |=> !CPU_NMI_REQ)
		else $error("Non-maskable request longer than one cycle");
	// In encoded mode the lower four pins give no separate requests.
	a_enc_split: assert property ($past(CPU_ENC_LEVEL) != '0 |-> CPU_PIN_REQ[3:0] == '0)
		else $error("Separate request beside encoded level");
endmodule : eid_chk

bind eid_top eid_chk chk_u (
	.CORE_CLK(CORE_CLK),
	.RST_B(RST_B),
	.STANDBY(STANDBY),
	.REG_ADDR(REG_ADDR),
	.REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA),
	.CPU_PIN_REQ(CPU_PIN_REQ),
	.CPU_ENC_LEVEL(CPU_ENC_LEVEL),
	.CPU_NMI_REQ(CPU_NMI_REQ)
);

// ### verification/ext_interrupt_detect_bench.sv
`timescale 1ns/1ps
// Drives registers and pins of the detector and compares against worked-out values.
module ext_interrupt_detect_bench;
	import eid_pkg::*;
	logic clk = 1'b0, rst_b = 1'b0, blk = 1'b0, stby = 1'b0, wr = 1'b0, rd = 1'b0, nmi, nreq, irq, seen;
	logic [6:0] want = 7'h7F;
	logic [5:0] pins, preq;
	logic [3:0] addr = 4'h0, enc;
	logic [15:0] wdata = 16'h0000, rdata, d;
	logic [31:0] lf = 32'h9D67;
	int n_errors = 0, compares = 0;

	// Clock at 50 ns period.
	always #25 clk = ~clk;

	eid_pin_model pm_u (.clk(clk), .want(want), .pins(pins), .nmi(nmi));
	eid_top dut_u (.CORE_CLK(clk), .RST_B(rst_b), .EXT_REQUEST_PIN(pins), .NMI_PIN(nmi),
		.CPU_BLOCK_BIT(blk), .STANDBY(stby), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
		.REG_RD(rd), .REG_RDATA(rdata), .CPU_PIN_REQ(preq), .CPU_ENC_LEVEL(enc),
		.CPU_NMI_REQ(nreq), .IRQ(irq));

	// Helpers for random values, expectations and bus cycles.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [15:0] sense_exp(input logic [15:0] v);
		return v & SENSE_WMASK;
	endfunction : sense_exp
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rchk(input logic [3:0] a, input logic [15:0] e, input string nm);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
		chk(nm, e, d);
	endtask : rchk
	// Drops the non-maskable pin and looks for one pulse in a short window.
	task automatic nmi_try(input logic e);
		@(posedge clk);
		want[6] <= 1'b0;
		seen = 1'b0;
		repeat (8) @(posedge clk) #1 seen |= nreq;
		chk("nmi", {15'h0, e}, {15'h0, seen});
		want[6] <= 1'b1;
		tick(4);
	endtask : nmi_try
	task automatic complete_run();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run

	// Guards the run against a hang.
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		complete_run();
	end

	// Main sequence of scenarios.
	initial begin
		tick(12);
		rst_b <= 1'b1;
		rchk(OFF_SENSE, SENSE_RST, "sense_rst");
		rchk(OFF_FLAGS, 16'(FLAGS_RST), "flags_rst");
		rchk(4'h2, 16'h0000, "unmapped");
		for (int i = 0; i < 6; i++) begin
			lf = lfsr(lf);
			wr_reg(OFF_SENSE, lf[15:0] & SENSE_WMASK);
			rchk(OFF_SENSE, sense_exp(lf[15:0]), "sense_rw");
		end
		rst_b <= 1'b0;
		tick(2);
		rst_b <= 1'b1;
		rchk(OFF_SENSE, SENSE_RST, "sense_rst2");
		rchk(OFF_FLAGS, 16'(FLAGS_RST), "flags_rst2");
		wr_reg(OFF_SENSE, 16'h0000);
		want[0] <= 1'b0;
		tick(5);
		rchk(OFF_FLAGS, 16'h0001, "edge_set");
		want[1] <= 1'b0;
		tick(5);
		wr_reg(OFF_FLAGS, 16'h0000);
		rchk(OFF_FLAGS, 16'h0002, "edge_clr");
		wr_reg(OFF_FLAGS, 16'h003F);
		rchk(OFF_FLAGS, 16'h0002, "write_one");
		wr_reg(OFF_SENSE, 16'h0020);
		want[2] <= 1'b0;
		tick(5);
		wr_reg(OFF_FLAGS, 16'h0000);
		rchk(OFF_FLAGS, 16'h0004, "level_hold");
		want[2] <= 1'b1;
		tick(5);
		rchk(OFF_FLAGS, 16'h0000, "level_drop");
		wr_reg(OFF_SENSE, 16'h8000);
		want[6] <= 1'b0;
		want[4] <= 1'b0;
		tick(6);
		chk("req_masked", 16'h0000, {10'h0, preq});
		rchk(OFF_FLAGS, 16'h0010, "flag_masked");
		want[6] <= 1'b1;
		tick(6);
		chk("req_open", 16'h0010, {10'h0, preq});
		wr_reg(OFF_SENSE, SENSE_RST);
		want[5:0] <= 6'h1A;
		tick(6);
		chk("enc", 16'h0005, {12'h0, enc});
		rchk(OFF_FLAGS, 16'h0030, "flag_hi");
		wr_reg(OFF_STATUS, 16'h0000);
		rchk(OFF_STATUS, 16'h0077, "status_ro");
		rchk(OFF_STATUS, 16'h0000, "status_rc");
		wr_reg(OFF_MASK, 16'h0040);
		nmi_try(1'b1);
		#1 chk("irq_set", 16'h0001, {15'h0, irq});
		wr_reg(OFF_MASK, 16'h0000);
		#1 chk("irq_masked", 16'h0000, {15'h0, irq});
		rchk(OFF_STATUS, 16'h0040, "status");
		wr_reg(OFF_MASK, 16'h0040);
		#1 chk("irq_clr", 16'h0000, {15'h0, irq});
		stby <= 1'b1;
		nmi_try(1'b0);
		stby <= 1'b0;
		blk <= 1'b1;
		nmi_try(1'b0);
		wr_reg(OFF_SENSE, 16'h6000);
		nmi_try(1'b1);
		complete_run();
	end
endmodule : ext_interrupt_detect_bench

// ### verilog/eid_top.sv
`timescale 1ns/1ps
// What this block does
// - Sense control is 16 bits, resets to 0x4000, survives standby.
// - Bit 15 set masks the pin and encoded-level requests, not the non-maskable request or IRQ, while the non-maskable pin is low.
// - In standby the non-maskable request is masked.
// - Bit 14 picks four separate pins or one encoded 15-level input; resets 1.
// - Pins 4 and 5 always stay independent request inputs.
// - With block bit set, bit 13 clear masks the non-maskable request.
// - Bit 12 of sense control reads 0; software writes 0.
// - Pin n uses bits 2n+1:2n: falling, rising, low, high; resets falling.
// - Request flags are 8 bits, reset to 0x00, survive standby.
// - Flag bits 7 and 6 read 0; software writes 0.
// - Flag bit n shows whether pin n has a request.
// - Edge flags clear only by writing 0 after reading them as 1, or for pins 3..0 on entering encoded mode.
// - Level flags follow the pin; software writes do not change them.
module eid_top (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic [eid_pkg::PIN_N-1:0] EXT_REQUEST_PIN,
	input wire logic NMI_PIN,
	input wire logic CPU_BLOCK_BIT,
	input wire logic STANDBY,
	input wire logic [eid_pkg::ADDR_W-1:0] REG_ADDR,
	input wire logic [eid_pkg::DATA_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [eid_pkg::DATA_W-1:0] REG_RDATA,
	output logic [eid_pkg::PIN_N-1:0] CPU_PIN_REQ,
	output logic [eid_pkg::ENC_N-1:0] CPU_ENC_LEVEL,
	output logic CPU_NMI_REQ,
	output logic IRQ
);
	import eid_pkg::*;

	// Decides whether a pin presents an edge event or an asserted level.
	function automatic logic sense_hit(input logic [1:0] sel, input logic cur, input logic prev);
		logic hit;
		hit = 1'b0;
		unique case (eid_sense_t'(sel))
			SENSE_FALL: hit = prev & ~cur;
			SENSE_RISE: hit = cur & ~prev;
			SENSE_LOW: hit = ~cur;
			SENSE_HIGH: hit = cur;
		endcase
		return hit;
	endfunction : sense_hit

	// True when the two-bit code selects level detection.
	function automatic logic is_level(input logic [1:0] sel);
		return sel[1];
	endfunction : is_level

	// Synchroniser and history state.
	logic [PIN_N-1:0] pin_s1_ff;
	logic [PIN_N-1:0] pin_s2_ff;
	logic [PIN_N-1:0] pin_prev_ff;
	logic nmi_s1_ff;
	logic nmi_s2_ff;
	logic nmi_prev_ff;
	logic [PIN_N-1:0] nxt_pin_s1;
	logic [PIN_N-1:0] nxt_pin_s2;
	logic [PIN_N-1:0] nxt_pin_prev;
	logic nxt_nmi_s1;
	logic nxt_nmi_s2;
	logic nxt_nmi_prev;

	// Two flip-flops on every pin before any detection logic looks at it.
	always_comb begin
		nxt_pin_s1 = EXT_REQUEST_PIN;
		nxt_pin_s2 = pin_s1_ff;
		nxt_pin_prev = pin_s2_ff;
		nxt_nmi_s1 = NMI_PIN;
		nxt_nmi_s2 = nmi_s1_ff;
		nxt_nmi_prev = nmi_s2_ff;
	end

	// Registers the synchroniser chain.
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pin_s1_ff <= '1;
			pin_s2_ff <= '1;
			pin_prev_ff <= '1;
			nmi_s1_ff <= 1'b1;
			nmi_s2_ff <= 1'b1;
			nmi_prev_ff <= 1'b1;
		end else begin
			pin_s1_ff <= nxt_pin_s1;
			pin_s2_ff <= nxt_pin_s2;
			pin_prev_ff <= nxt_pin_prev;
			nmi_s1_ff <= nxt_nmi_s1;
			nmi_s2_ff <= nxt_nmi_s2;
			nmi_prev_ff <= nxt_nmi_prev;
		end
	end

	// Register bus decode.
	logic wr_sense;
	logic wr_flags;
	logic wr_mask;
	logic rd_flags;
	logic rd_status;

	// One decoded strobe per register access that changes state.
	always_comb begin
		wr_sense = REG_WR && (REG_ADDR == OFF_SENSE);
		wr_flags = REG_WR && (REG_ADDR == OFF_FLAGS);
		wr_mask = REG_WR && (REG_ADDR == OFF_MASK);
		rd_flags = REG_RD && (REG_ADDR == OFF_FLAGS);
		rd_status = REG_RD && (REG_ADDR == OFF_STATUS);
	end

	// Sense control register and interrupt mask register.
	logic [DATA_W-1:0] sense_ff;
	logic [DATA_W-1:0] nxt_sense;
	logic [STAT_W-1:0] mask_ff;
	logic [STAT_W-1:0] nxt_mask;

	// Software writes; the reserved bit never stores a one.
	always_comb begin
		nxt_sense = sense_ff;
		nxt_mask = mask_ff;
		if (wr_sense) begin
			nxt_sense = REG_WDATA & SENSE_WMASK;
		end
		if (wr_mask) begin
			nxt_mask = REG_WDATA[STAT_W-1:0];
		end
	end

	// Only reset and software writes touch these registers; standby leaves them alone.
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			sense_ff <= SENSE_RST;
			mask_ff <= STAT_RST;
		end else begin
			sense_ff <= nxt_sense;
			mask_ff <= nxt_mask;
		end
	end

	// Detection per pin.
	logic enc_mode;
	logic [PIN_N-1:0] pin_hit;
	logic [PIN_N-1:0] pin_level;
	logic [PIN_N-1:0] pin_active;

	// Each pin uses its own two-bit field; pins 3..0 drop out in encoded mode.
	always_comb begin
		enc_mode = sense_ff[BIT_ENC_SEL];
		for (int n = 0; n < PIN_N; n++) begin
			pin_hit[n] = sense_hit(sense_ff[2*n+1 -: 2], pin_s2_ff[n], pin_prev_ff[n]);
			pin_level[n] = is_level(sense_ff[2*n+1 -: 2]);
			pin_active[n] = !(enc_mode && (n < ENC_N));
		end
	end

	// Request flags and the armed-for-clear bits.
	logic [PIN_N-1:0] flag_ff;
	logic [PIN_N-1:0] armed_ff;
	logic [PIN_N-1:0] nxt_flag;
	logic [PIN_N-1:0] nxt_armed;
	logic [PIN_N-1:0] flag_rise;

	// Edge flags latch; level flags track the pin; clears need a prior read of one.
	// The armed bit remembers that software has seen the flag as one.
	// Without it a blind write of zero could drop a request that software never saw.
	// A new edge in the clearing cycle wins, so no request is ever lost.
	// Leaving edge mode or entering encoded mode disarms the pin.
	// Writes of one are ignored, so a read-modify-write cannot set a flag.
	// Level pins ignore writes altogether and follow the synchronised pin.
	always_comb begin
		nxt_flag = flag_ff;
		nxt_armed = armed_ff;
		for (int n = 0; n < PIN_N; n++) begin
			if (!pin_active[n]) begin
				nxt_flag[n] = 1'b0;
				nxt_armed[n] = 1'b0;
			end else if (pin_level[n]) begin
				nxt_flag[n] = pin_hit[n];
				nxt_armed[n] = 1'b0;
			end else begin
				if (rd_flags && flag_ff[n]) begin
					nxt_armed[n] = 1'b1;
				end
				if (wr_flags && armed_ff[n] && !REG_WDATA[n]) begin
					nxt_flag[n] = 1'b0;
					nxt_armed[n] = 1'b0;
				end
				if (pin_hit[n]) begin
					nxt_flag[n] = 1'b1;
				end
			end
		end
		flag_rise = nxt_flag & ~flag_ff;
	end

	// Flags reset to zero and keep their value through standby.
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			flag_ff <= FLAGS_RST[PIN_N-1:0];
			armed_ff <= '0;
		end else begin
			flag_ff <= nxt_flag;
			armed_ff <= nxt_armed;
		end
	end

	// Requests toward the processor.
	logic mask_all;
	logic nmi_event;
	logic nmi_accept;
	logic [PIN_N-1:0] nxt_pin_req;
	logic [ENC_N-1:0] nxt_enc_level;
	logic nxt_nmi_req;
	logic [PIN_N-1:0] pin_req_ff;
	logic [ENC_N-1:0] enc_level_ff;
	logic nmi_req_ff;

	// Masking gates the outputs only, never the flags.
	always_comb begin
		mask_all = sense_ff[BIT_MASK_ALL] && !nmi_s2_ff;
		nmi_event = nmi_prev_ff && !nmi_s2_ff;
		nmi_accept = nmi_event && !STANDBY;
		if (CPU_BLOCK_BIT && !sense_ff[BIT_BL_OVR]) begin
			nmi_accept = 1'b0;
		end
		nxt_pin_req = mask_all ? '0 : flag_ff;
		nxt_enc_level = '0;
		if (enc_mode && !mask_all) begin
			nxt_enc_level = ~pin_s2_ff[ENC_N-1:0];
		end
		nxt_nmi_req = nmi_accept;
	end

	// Registered request outputs.
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pin_req_ff <= '0;
			enc_level_ff <= '0;
			nmi_req_ff <= 1'b0;
		end else begin
			pin_req_ff <= nxt_pin_req;
			enc_level_ff <= nxt_enc_level;
			nmi_req_ff <= nxt_nmi_req;
		end
	end

	// Sticky interrupt status, cleared by a read.
	logic [STAT_W-1:0] status_ff;
	logic [STAT_W-1:0] nxt_status;
	logic [STAT_W-1:0] stat_set;

	// New events win over the clear caused by a read in the same cycle.
	always_comb begin
		stat_set = {nmi_accept, flag_rise};
		nxt_status = status_ff;
		if (rd_status) begin
			nxt_status = STAT_RST;
		end
		nxt_status = nxt_status | stat_set;
	end

	// Status register.
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			status_ff <= STAT_RST;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// Read data path, valid the cycle after the read strobe.
	logic [DATA_W-1:0] rdata_ff;
	logic [DATA_W-1:0] nxt_rdata;

	// Unmapped addresses and reserved bits read as zero.
	always_comb begin
		nxt_rdata = '0;
		if (REG_RD) begin
			unique case (REG_ADDR)
				OFF_SENSE: nxt_rdata = sense_ff & SENSE_WMASK;
				OFF_FLAGS: nxt_rdata = {{(DATA_W-PIN_N){1'b0}}, flag_ff};
				OFF_STATUS: nxt_rdata = {{(DATA_W-STAT_W){1'b0}}, status_ff};
				OFF_MASK: nxt_rdata = {{(DATA_W-STAT_W){1'b0}}, mask_ff};
				default: nxt_rdata = '0;
			endcase
		end
	end

	// Registers the read data.
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// Outputs.
	assign REG_RDATA = rdata_ff;
	assign CPU_PIN_REQ = pin_req_ff;
	assign CPU_ENC_LEVEL = enc_level_ff;
	assign CPU_NMI_REQ = nmi_req_ff;
	assign IRQ = |(status_ff & mask_ff);
endmodule : eid_top
